// *** src/wdc_pkg.sv ***
// package: register map, field positions, reset values and counts of the watchdog control block
package wdc_pkg;
  // register map (byte offsets on the plain register port)
  localparam logic [3:0] WDC_ADDR_CTRL = 4'h0;   // watchdog_control_register
  localparam logic [3:0] WDC_ADDR_CAUSE = 4'h1;  // reset cause, bit 3 = watchdog cause
  localparam logic [3:0] WDC_ADDR_CFG = 4'h2;    // status: safety level, enable state
  // control and cause register field positions
  localparam int WDC_BIT_IRQ_FLAG = 7;
  localparam int WDC_BIT_IRQ_EN = 6;
  localparam int WDC_BIT_SEL3 = 5;
  localparam int WDC_BIT_KEY = 4;
  localparam int WDC_BIT_WDE = 3;
  localparam int WDC_BIT_CAUSE = 3;
  // select reset value, last valid code and reserved fallback
  localparam logic [3:0] WDC_SEL_RST = 4'h0;
  localparam logic [3:0] WDC_SEL_MAX = 4'h9;     // last valid select code
  localparam logic [3:0] WDC_SEL_RESERVED_USE = 4'h9;
  // timing
  localparam int WDC_KEY_CYCLES = 4;             // change key lifetime in processor clocks
  localparam int WDC_BASE_TIMEOUT = 2048;        // oscillator cycles for select code 0
  localparam int WDC_CNT_W = 21;                 // enough for 1048576 cycles
  localparam int WDC_OSC_HZ = 128000;            // watchdog oscillator rate
  localparam int WDC_SYS_HZ = 10000000;          // processor clock rate
  localparam int WDC_OSC_DIV = WDC_SYS_HZ / WDC_OSC_HZ / 2; // half-period in processor clocks
endpackage

// *** src/wdc_tick_if.sv ***
// interface: run, restart, select and time-out carrier between the watchdog core and its counter
`timescale 1ns/1ps
`default_nettype none
interface wdc_tick_if;
  logic run;
  logic restart;
  logic [3:0] sel;
  logic timeout;
  modport ctrl (output run, output restart, output sel, input timeout);
  modport cnt (input run, input restart, input sel, output timeout);
endinterface
`default_nettype wire

// *** src/wdc_counter.sv ***
// module: watchdog oscillator and prescaled time-out counter
`timescale 1ns/1ps
`default_nettype none
module wdc_counter
  import wdc_pkg::*;
#(
  parameter int OSC_DIV = WDC_OSC_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control side
  wdc_tick_if.cnt tk
);
  logic [7:0] div_r;
  logic osc_r;
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_s3_r;
  logic [WDC_CNT_W-1:0] cnt_r;
  logic timeout_r;
  wire osc_rise;
  wire [WDC_CNT_W-1:0] limit;

  // ----------------------------------------------------------------
  // oscillator model and synchroniser
  // ----------------------------------------------------------------
  // separate oscillator near 128 kHz
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_r <= 8'h00;
      osc_r <= 1'b0;
    end else if (div_r == 8'(OSC_DIV - 1)) begin
      div_r <= 8'h00;
      osc_r <= ~osc_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // oscillator edge brought through two flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_r;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  assign osc_rise = osc_s2_r & ~osc_s3_r;

  // ----------------------------------------------------------------
  // time-out counter
  // ----------------------------------------------------------------
  // 2048 cycles doubled per code step
  assign limit = WDC_CNT_W'(WDC_BASE_TIMEOUT) << tk.sel;

  // restart on kick, disable or reset
  always_ff @(posedge sys_clk) begin
    if (srst || tk.restart || !tk.run) begin
      cnt_r <= '0;
      timeout_r <= 1'b0;
    // compare at or above limit - 1 on a rise: a smaller select must not let the count overshoot
    end else if (osc_rise && (cnt_r >= limit - WDC_CNT_W'(1))) begin
      cnt_r <= '0;
      timeout_r <= 1'b1;
    end else begin
      if (osc_rise) cnt_r <= cnt_r + WDC_CNT_W'(1);
      timeout_r <= 1'b0;
    end
  end
  assign tk.timeout = timeout_r;
endmodule
`default_nettype wire

// *** src/wdc_top.sv ***
// module: watchdog control register, timed change key and time-out actions
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module wdc_top
  import wdc_pkg::*;
#(
  parameter int OSC_DIV = WDC_OSC_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // processor side
  input wire logic safety_level_fuse,
  input wire logic global_irq_enable,
  input wire logic kick_instruction,
  input wire logic irq_vector_ack,
  output logic wdt_irq,
  output logic wdt_reset
);
  logic irq_flag_r;
  logic irq_en_r;
  logic wde_r;
  logic key_r;
  logic [2:0] key_cnt_r;
  logic [3:0] sel_r;
  logic cause_r;
  logic lvl2_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic rst_pulse_r;
  wdc_tick_if tk ();

  wire wr_ctrl;
  wire wr_cause;
  wire [3:0] sel_wr;
  wire [3:0] sel_legal;
  wire wde_eff;
  wire to_irq;
  wire to_reset;
  wire key_set;
  wire [7:0] ctrl_view;
  wire [7:0] rd_mux;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == WDC_ADDR_CTRL);
  assign wr_cause = reg_wr && (reg_addr == WDC_ADDR_CAUSE);
  assign sel_wr = {reg_wdata[WDC_BIT_SEL3], reg_wdata[2:0]};
  // reserved codes fall back to a valid code
  assign sel_legal = (sel_wr > WDC_SEL_MAX) ? WDC_SEL_RESERVED_USE : sel_wr;
  // level one enable forced by reset cause; level two always on
  assign wde_eff = wde_r | lvl2_r | cause_r;
  assign to_irq = tk.timeout && irq_en_r;
  assign to_reset = tk.timeout && !irq_en_r && wde_eff;
  assign key_set = wr_ctrl && reg_wdata[WDC_BIT_KEY] && reg_wdata[WDC_BIT_WDE];
  assign ctrl_view = {irq_flag_r, irq_en_r, sel_r[3], key_r, wde_eff, sel_r[2:0]};
  assign rd_mux = (reg_addr == WDC_ADDR_CTRL) ? ctrl_view :
                  (reg_addr == WDC_ADDR_CAUSE) ? {4'h0, cause_r, 3'h0} :
                  (reg_addr == WDC_ADDR_CFG) ? {6'h00, lvl2_r, wde_eff} : 8'h00;

  // counter hookup; stopped when both enables clear
  assign tk.run = wde_eff | irq_en_r;
  assign tk.restart = kick_instruction;
  assign tk.sel = sel_r;

  wdc_counter #(.OSC_DIV(OSC_DIV)) u_cnt (
    .sys_clk(sys_clk),
    .srst(srst),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // safety level capture
  // ----------------------------------------------------------------
  // fuse sampled by a clocked process during reset
  always_ff @(posedge sys_clk) begin
    if (srst) lvl2_r <= safety_level_fuse;
  end

  // ----------------------------------------------------------------
  // change key and its four-cycle window
  // ----------------------------------------------------------------
  // key clears four clocks after it was written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_r <= 1'b0;
      key_cnt_r <= 3'h0;
    end else if (key_set) begin
      key_r <= 1'b1;
      key_cnt_r <= 3'(WDC_KEY_CYCLES - 1);
    end else if (wr_ctrl || key_cnt_r == 3'h0) begin
      key_r <= 1'b0;
      key_cnt_r <= 3'h0;
    end else begin
      key_cnt_r <= key_cnt_r - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // enable and select
  // ----------------------------------------------------------------
  // set freely; clear only with key
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wde_r <= 1'b0;
    end else if (wr_ctrl && reg_wdata[WDC_BIT_WDE]) begin
      wde_r <= 1'b1;
    end else if (wr_ctrl && key_r) begin
      wde_r <= 1'b0;
    end
  end

  // select written only under key (free in level one)
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_r <= WDC_SEL_RST;
    end else if (wr_ctrl && (key_r || !lvl2_r)) begin
      sel_r <= sel_legal;
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable and flag
  // ----------------------------------------------------------------
  // time-out with enable set clears interrupt enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_en_r <= 1'b0;
    end else if (to_irq && wde_eff) begin
      irq_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_r <= reg_wdata[WDC_BIT_IRQ_EN];
    end
  end

  // set on time-out wins; vector clear; write one clears
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_flag_r <= 1'b0;
    end else if (to_irq) begin
      irq_flag_r <= 1'b1;
    end else if (irq_vector_ack || (wr_ctrl && reg_wdata[WDC_BIT_IRQ_FLAG])) begin
      irq_flag_r <= 1'b0;
    end
  end

  // reset cause flag, kept across the watchdog pulse; software writes zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cause_r <= 1'b0;
    end else if (to_reset) begin
      cause_r <= 1'b1;
    end else if (wr_cause && !reg_wdata[WDC_BIT_CAUSE]) begin
      cause_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // interrupt gate; one-clock reset pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
      rst_pulse_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      irq_r <= irq_flag_r && irq_en_r && global_irq_enable;
      rst_pulse_r <= to_reset;
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign wdt_irq = irq_r;
  assign wdt_reset = rst_pulse_r;
  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// *** verif/wdc_top_props.sv ***
// checker: port-level properties of the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdc_top_props
  import wdc_pkg::*;
#(
  parameter int OSC_DIV = WDC_OSC_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // processor side
  input wire logic safety_level_fuse,
  input wire logic global_irq_enable,
  input wire logic kick_instruction,
  input wire logic irq_vector_ack,
  input wire logic wdt_irq,
  input wire logic wdt_reset
);
  // ----------------------------------------
  // access decode and properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire rd_ctrl = reg_rd && reg_addr == WDC_ADDR_CTRL;
  wire wr_ctrl = reg_wr && reg_addr == WDC_ADDR_CTRL;
  quiet_after_rst_a: assert property (
    $fell(srst) |-> !wdt_irq && !wdt_reset) else $error("output active after reset");
  reset_pulse_a: assert property (
    wdt_reset |=> !wdt_reset) else $error("reset pulse longer than one clock");
  irq_gie_a: assert property (
    !global_irq_enable |=> !wdt_irq) else $error("irq without global enable");
  ack_clear_a: assert property (
    irq_vector_ack |=> ##1 !wdt_irq) else $error("irq stays after vector entry");
  lvl2_enabled_a: assert property (
    rd_ctrl && safety_level_fuse |=> reg_rdata[WDC_BIT_WDE]) else $error("level two disabled");
  status_map_a: assert property (
    reg_rd && reg_addr == WDC_ADDR_CFG |=> reg_rdata[7:1] == {6'h00, safety_level_fuse})
    else $error("status read wrong");
  key_expire_a: assert property (
    wr_ctrl && reg_wdata[WDC_BIT_KEY] ##1 (!reg_wr) [*6] ##0 rd_ctrl |=> !reg_rdata[WDC_BIT_KEY])
    else $error("change key did not expire");
  flag_w1c_a: assert property (
    wr_ctrl && reg_wdata[WDC_BIT_IRQ_FLAG] ##1 rd_ctrl |=> !reg_rdata[WDC_BIT_IRQ_FLAG])
    else $error("flag not cleared by write");
  // main scenarios reached
  cover property ($rose(wdt_irq));
  cover property (wdt_reset);
  cover property (irq_vector_ack && wdt_irq);
endmodule
bind wdc_top wdc_top_props #(.OSC_DIV(OSC_DIV)) wdc_top_props_i (.sys_clk, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .safety_level_fuse, .global_irq_enable,
  .kick_instruction, .irq_vector_ack, .wdt_irq, .wdt_reset);
`default_nettype wire

// *** verif/wdc_top_tb.sv ***
// testbench: register-level scenarios for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdc_top_tb
  import wdc_pkg::*;
();
  localparam int OSC_DIV = 1;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic safety_level_fuse = 1'b0;
  logic global_irq_enable = 1'b0;
  logic kick_instruction = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic [7:0] reg_rdata;
  logic wdt_irq;
  logic wdt_reset;
  int error_cnt = 0;
  int checks = 0;
  int rst_cnt = 0;
  int n;
  int r0;
  // ----------------------------------------
  // clock, reset counter and device
  // ----------------------------------------
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wdt_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  wdc_top #(.OSC_DIV(OSC_DIV)) wdc_top_i (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .safety_level_fuse, .global_irq_enable, .kick_instruction,
    .irq_vector_ack, .wdt_irq, .wdt_reset);
  // compare and count
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one write cycle; keep holds the strobe for a back-to-back write
  task automatic wr(input logic [7:0] d, input bit k = 0, input logic [3:0] a = WDC_ADDR_CTRL);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    if (!k) reg_wr <= 1'b0;
  endtask
  // one read cycle, data taken in the cycle after the strobe
  task automatic rc(input logic [7:0] exp, input logic [3:0] a = WDC_ADDR_CTRL);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  // bounded wait for the interrupt or the reset pulse
  task automatic wait_out(input bit want_rst, output int cnt);
    cnt = 0;
    while ((want_rst ? wdt_reset : wdt_irq) !== 1'b1 && cnt < 20000) begin
      @(posedge sys_clk);
      cnt++;
    end
    chk("time-out seen", {7'h0, cnt < 20000}, 8'h01);
  endtask
  task automatic do_rst(input logic fuse);
    srst <= 1'b1;
    safety_level_fuse <= fuse;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end
  initial begin
    do_rst(1'b0);
    rc(8'h00, WDC_ADDR_CAUSE);
    rc(8'h00, 4'hF);
    wr(8'h08);
    rc(8'h01, WDC_ADDR_CFG);
    wr(8'h00);
    rc(8'h08);
    wr(8'h18);
    repeat (5) @(posedge sys_clk);
    rc(8'h08);
    wr(8'h00);
    rc(8'h08);
    wr(8'h18, 1'b1);
    wr(8'h00);
    rc(8'h00);
    global_irq_enable <= 1'b1;
    wr(8'h40);
    wait_out(1'b0, n);
    rc(8'hC0);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("wdt_irq", {7'h0, wdt_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    wr(8'hC0);
    rc(8'h40);
    wait_out(1'b0, n);
    irq_vector_ack <= 1'b1;
    @(posedge sys_clk);
    irq_vector_ack <= 1'b0;
    rc(8'h40);
    wr(8'h48);
    // time-out clears the interrupt enable, so no request is raised
    repeat (4200) @(posedge sys_clk);
    chk("wdt_irq masked", {7'h0, wdt_irq}, 8'h00);
    rc(8'h88);
    wr(8'h88);
    wait_out(1'b1, n);
    rc(8'h08, WDC_ADDR_CAUSE);
    wr(8'h18, 1'b1);
    wr(8'h00);
    rc(8'h08);
    wr(8'h00, 1'b0, WDC_ADDR_CAUSE);
    wr(8'h18, 1'b1);
    wr(8'h00);
    rc(8'h00);
    do_rst(1'b1);
    rc(8'h03, WDC_ADDR_CFG);
    wr(8'h18, 1'b1);
    wr(8'h00);
    rc(8'h08);
    wr(8'h0B);
    rc(8'h08);
    wr(8'h18, 1'b1);
    wr(8'h29);
    rc(8'h29);
    for (int s = 0; s < 2; s++) begin
      wr(8'h18, 1'b1);
      wr(8'h08 | 8'(s));
      r0 = rst_cnt;
      repeat (3) begin
        repeat (3000) @(posedge sys_clk);
        kick_instruction <= 1'b1;
        @(posedge sys_clk);
        kick_instruction <= 1'b0;
      end
      chk("resets while kicked", 8'(rst_cnt - r0), 8'h00);
      wait_out(1'b1, n);
      chk("period", {7'h0, n >= (4096 << s) - 8 && n <= (4096 << s) + 16}, 8'h01);
    end
    close_out();
  end
endmodule
`default_nettype wire
